// ==== rtl/pif_flags.sv ====
// Peripheral flag banks 4 to 7, enables, and CPU request.
// Assumes synchronous event inputs and an AXI4-Lite master.
`timescale 1ns/1ns
module pif_flags
  import pif_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire pif_events_t i_events,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_periph_pending,
  output logic o_cpu_irq_req,
  output logic o_irq
);

  // ==========================================================
  // Storage
  pif_banks_t flags;
  pif_banks_t enables;
  logic [7:0] global_ctrl;
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic gate_prev;
  logic req_prev;

  // ==========================================================
  // Write channel capture
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;

  function automatic logic known_addr(input logic [7:0] a);
    unique case (a)
      ADDR_GLOBAL_CTRL, ADDR_ENABLE4, ADDR_ENABLE5, ADDR_ENABLE6,
      ADDR_ENABLE7, ADDR_FLAG4, ADDR_FLAG5, ADDR_FLAG6, ADDR_FLAG7,
      ADDR_EVT_STATUS, ADDR_EVT_MASK: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction : known_addr

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register bits
  logic lane0;
  assign lane0 = wr_fire && w_strb[0];

  function automatic logic hit(input logic [7:0] a);
    hit = lane0 && (aw_addr == a);
  endfunction : hit

  // ==========================================================
  // Hardware set events
  pif_banks_t hw_set;
  logic timer8_evt;
  logic gate_fall;

  // 1:1 ratio uses period match instead of postscaler
  assign timer8_evt = i_events.timer8_ratio_1to1 ?
      i_events.timer8_period_match :
      i_events.timer8_postscale_ovf;
  assign gate_fall = gate_prev && !i_events.timer16_gate_active;

  always_comb begin
    hw_set = '0;
    hw_set.bank4[POS_TIMER8_EVT] = timer8_evt;
    hw_set.bank4[POS_TIMER16_OVF] = i_events.timer16_ovf;
    hw_set.bank5[POS_CELL1+3:POS_CELL1] = i_events.cell_event;
    hw_set.bank5[POS_GATE_DONE] = gate_fall;
    hw_set.bank6[POS_CAP2] = i_events.capture_event[1];
    hw_set.bank6[POS_CAP1] = i_events.capture_event[0];
    hw_set.bank7[POS_NVM_DONE] = i_events.nvm_done;
    hw_set.bank7[POS_OSC_ROLL] = i_events.osc_rollover;
    hw_set.bank7[POS_WAVE_SHUT] = i_events.wave_shutdown;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_prev <= 1'b0;
    end else begin
      gate_prev <= i_events.timer16_gate_active;
    end
  end

  // ==========================================================
  // Flag banks: set wins over a software clear in the same cycle
  localparam logic [7:0] FLAG_ADDR [4] = '{ADDR_FLAG4, ADDR_FLAG5,
      ADDR_FLAG6, ADDR_FLAG7};
  localparam logic [7:0] EN_ADDR [4] = '{ADDR_ENABLE4, ADDR_ENABLE5,
      ADDR_ENABLE6, ADDR_ENABLE7};
  localparam logic [7:0] IMPL [4] = '{IMPL_BANK4, IMPL_BANK5,
      IMPL_BANK6, IMPL_BANK7};

  logic [3:0][7:0] flag_q;
  logic [3:0][7:0] en_q;
  logic [3:0][7:0] set_v;
  assign set_v = {hw_set.bank4, hw_set.bank5, hw_set.bank6, hw_set.bank7};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          flag_q[3-g] <= RST_FLAG;
        end else if (hit(FLAG_ADDR[g])) begin
          // Software write, hardware set ORed on top
          flag_q[3-g] <= (w_data[7:0] | set_v[3-g]) & IMPL[g];
        end else begin
          // Sets ignore all enables
          flag_q[3-g] <= flag_q[3-g] | (set_v[3-g] & IMPL[g]);
        end
      end

      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          en_q[3-g] <= RST_ENABLE;
        end else if (hit(EN_ADDR[g])) begin
          en_q[3-g] <= w_data[7:0] & IMPL[g];
        end
      end
    end
  endgenerate

  assign flags = flag_q;
  assign enables = en_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      global_ctrl <= RST_ENABLE;
    end else if (hit(ADDR_GLOBAL_CTRL)) begin
      global_ctrl <= w_data[7:0] & IMPL_GLOBAL;
    end
  end

  // ==========================================================
  // Request toward the CPU
  // Stale flags fire at once when enabled; software clears them first
  assign o_periph_pending = |(flag_q & en_q);
  assign o_cpu_irq_req = o_periph_pending && global_ctrl[POS_GIE] &&
      global_ctrl[POS_PERIPHERAL_IRQ_ENABLE];

  // ==========================================================
  // Block event status, write one to clear, set wins
  logic [1:0] evt_set;
  logic [1:0] evt_clr;
  assign evt_set = {wr_fire && !known_addr(aw_addr),
      o_cpu_irq_req && !req_prev};
  assign evt_clr = hit(ADDR_EVT_STATUS) ? w_data[1:0] : 2'h0;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_status <= RST_EVT;
      req_prev <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      req_prev <= o_cpu_irq_req;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_mask <= RST_EVT;
    end else if (hit(ADDR_EVT_MASK)) begin
      evt_mask <= w_data[1:0];
    end
  end

  assign o_irq = |(evt_status & evt_mask);

  // ==========================================================
  // Read channel, one cycle latency
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      ADDR_GLOBAL_CTRL: rd_byte = global_ctrl;
      ADDR_ENABLE4: rd_byte = en_q[3];
      ADDR_ENABLE5: rd_byte = en_q[2];
      ADDR_ENABLE6: rd_byte = en_q[1];
      ADDR_ENABLE7: rd_byte = en_q[0];
      ADDR_FLAG4: rd_byte = flag_q[3];
      ADDR_FLAG5: rd_byte = flag_q[2];
      ADDR_FLAG6: rd_byte = flag_q[1];
      ADDR_FLAG7: rd_byte = flag_q[0];
      ADDR_EVT_STATUS: rd_byte = {6'h00, evt_status};
      ADDR_EVT_MASK: rd_byte = {6'h00, evt_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_set4;
    i_events.timer16_ovf;
  endsequence

  AST_T16_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_set4 |=> flag_q[3][POS_TIMER16_OVF])
    else $error("timer16 flag not set");

  AST_T8_RATIO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_events.timer8_ratio_1to1 && i_events.timer8_period_match
    |=> flag_q[3][POS_TIMER8_EVT])
    else $error("timer8 match not flagged");

  AST_GATE_FALL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(i_events.timer16_gate_active) |=> flag_q[2][POS_GATE_DONE])
    else $error("gate done not flagged");

  AST_CELLS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_events.cell_event[3] |=> flag_q[2][7])
    else $error("cell 4 not flagged");

  AST_UNIMPL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (flag_q[3][7:2] == 6'h00) && (flag_q[0][7:6] == 2'h0)
    && (en_q[1][7:2] == 6'h00))
    else $error("unimplemented bit set");

  AST_SET_WINS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hit(ADDR_FLAG7) && i_events.nvm_done |=> flag_q[0][POS_NVM_DONE])
    else $error("clear beat nvm event");

  AST_SW_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hit(ADDR_FLAG6) && !w_data[POS_CAP1] && !i_events.capture_event[0]
    |=> !flag_q[1][POS_CAP1])
    else $error("software clear failed");

  AST_REQ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cpu_irq_req == ((|(flag_q & en_q)) && global_ctrl[7]
    && global_ctrl[6]))
    else $error("request mismatch");

  AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    flag_q[0][POS_OSC_ROLL] && !hit(ADDR_FLAG7)
    |=> flag_q[0][POS_OSC_ROLL])
    else $error("flag dropped without clear");

endmodule : pif_flags

// ==== rtl/pif_pkg.sv ====
// Constants, types and register map for peripheral flag banks 4 to 7.
// Assumes one 100 MHz clock and an AXI4-Lite master for software.
//
// Operation
// - Timer8 flag sets on postscaler overflow, or period match at 1:1.
// - Timer16 overflow sets its flag, which holds until software clears.
// - Flags set on their events regardless of any enable bit.
// - Unimplemented bits read zero; writes to them do nothing.
// - Logic cell 4..1 events set bank 5 bits 7..4, held.
// - Timer16 gate going inactive sets bank 5 bit 0.
// - Capture units 2 and 1 set bank 6 bits 1 and 0.
// - Nonvolatile operation completion sets bank 7 bit 5.
// - Oscillator accumulator rollover sets bank 7 bit 4.
// - Waveform generator shutdown sets bank 7 bit 0.
// - All flags clear to zero on every reset.
// - Software reads and writes flags; writing zero clears one.
package pif_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE4 = 8'h04;
  localparam logic [7:0] ADDR_ENABLE5 = 8'h08;
  localparam logic [7:0] ADDR_ENABLE6 = 8'h0C;
  localparam logic [7:0] ADDR_ENABLE7 = 8'h10;
  localparam logic [7:0] ADDR_FLAG4 = 8'h14;
  localparam logic [7:0] ADDR_FLAG5 = 8'h18;
  localparam logic [7:0] ADDR_FLAG6 = 8'h1C;
  localparam logic [7:0] ADDR_FLAG7 = 8'h20;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h24;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h28;

  // ==========================================================
  // Implemented bit masks per bank
  localparam logic [7:0] IMPL_BANK4 = 8'h03;
  localparam logic [7:0] IMPL_BANK5 = 8'hF1;
  localparam logic [7:0] IMPL_BANK6 = 8'h03;
  localparam logic [7:0] IMPL_BANK7 = 8'h31;
  localparam logic [7:0] IMPL_GLOBAL = 8'hC0;

  // ==========================================================
  // Field positions
  localparam int POS_TIMER16_OVF = 0;
  localparam int POS_TIMER8_EVT = 1;
  localparam int POS_GATE_DONE = 0;
  localparam int POS_CELL1 = 4;
  localparam int POS_CAP1 = 0;
  localparam int POS_CAP2 = 1;
  localparam int POS_WAVE_SHUT = 0;
  localparam int POS_OSC_ROLL = 4;
  localparam int POS_NVM_DONE = 5;
  localparam int POS_GIE = 7;
  localparam int POS_PERIPHERAL_IRQ_ENABLE = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;

  // Event status bits: request rise, write to unmapped address
  localparam int EVT_REQ = 0;
  localparam int EVT_BADADDR = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic timer8_postscale_ovf;
    logic timer8_period_match;
    logic timer8_ratio_1to1;
    logic timer16_ovf;
    logic timer16_gate_active;
    logic [3:0] cell_event;
    logic [1:0] capture_event;
    logic nvm_done;
    logic osc_rollover;
    logic wave_shutdown;
  } pif_events_t;

  typedef struct packed {
    logic [7:0] bank4;
    logic [7:0] bank5;
    logic [7:0] bank6;
    logic [7:0] bank7;
  } pif_banks_t;

endpackage : pif_pkg

// ==== testbench/pif_event_src.sv ====
// Peripheral event source model facing the flag banks.
// Assumes the bench calls pulse from its own process.
`timescale 1ns/1ns
module pif_event_src
  import pif_pkg::*;
(
  input wire logic i_ref_clk,
  output pif_events_t o_events
);
  // =====================================
  // Pulses
  // Quiet between events so no flag sets by accident
  initial o_events = '0;

  task pulse(input pif_events_t e);
    @(posedge i_ref_clk);
    o_events <= e;
    @(posedge i_ref_clk);
    o_events <= '0;
  endtask : pulse
endmodule : pif_event_src

// ==== testbench/tb_peripheral_irq_flags_4_to_7.sv ====
// Self-checking bench for the flag banks 4 to 7.
// Assumes pif_flags answers over AXI4-Lite on one clock.
`timescale 1ns/1ns
module tb_peripheral_irq_flags_4_to_7
  import pif_pkg::*;
;
  // =====================================
  // Signals
  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  pif_events_t ev;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pend, req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int n_tests = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  pif_event_src i_src (.i_ref_clk(i_ref_clk), .o_events(ev));

  pif_flags i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_events(ev),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_periph_pending(pend), .o_cpu_irq_req(req), .o_irq(irq)
  );

  // =====================================
  // Shared tasks
  task results;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask : check

  // Bounded waits: a silent slave ends the run
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge i_ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_ref_clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (n == 40) begin
      miscompares++;
      results();
    end
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge i_ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_ref_clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    if (n == 40) begin
      miscompares++;
      results();
    end
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rchk

  // Pending, request, interrupt once the outputs settle
  task outs(input logic [2:0] e);
    @(negedge i_ref_clk);
    check({29'h0, pend, req, irq}, {29'h0, e});
  endtask : outs

  // =====================================
  // Scenarios
  task t_reset;
    for (int a = 0; a <= 40; a += 4) rchk(8'(a), 32'h0);
  endtask : t_reset

  task t_events;
    logic [13:0] e_t [10] = '{14'h2000, 14'h1800, 14'h1000, 14'h0400,
      14'h01E0, 14'h0200, 14'h0018, 14'h0004, 14'h0002, 14'h0001};
    logic [7:0] a_t [10] = '{ADDR_FLAG4, ADDR_FLAG4, ADDR_FLAG4,
      ADDR_FLAG4, ADDR_FLAG5, ADDR_FLAG5, ADDR_FLAG6, ADDR_FLAG7,
      ADDR_FLAG7, ADDR_FLAG7};
    logic [7:0] x_t [10] = '{8'h02, 8'h02, 8'h00, 8'h01, 8'hF0, 8'h01,
      8'h03, 8'h20, 8'h10, 8'h01};
    for (int i = 0; i < 10; i++) begin
      i_src.pulse(e_t[i]);
      rchk(a_t[i], {24'h0, x_t[i]});
      wr(a_t[i], 32'h0);
      rchk(a_t[i], 32'h0);
    end
  endtask : t_events

  task t_sw;
    logic [7:0] m_t [4] = '{IMPL_BANK4, IMPL_BANK5, IMPL_BANK6,
      IMPL_BANK7};
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_ENABLE4 + 8'(4 * i), 32'hFFFF_FFFF);
      rchk(ADDR_ENABLE4 + 8'(4 * i), {24'h0, m_t[i % 4]});
      wr(ADDR_ENABLE4 + 8'(4 * i), 32'h0);
      rchk(ADDR_ENABLE4 + 8'(4 * i), 32'h0);
    end
    wr(ADDR_GLOBAL_CTRL, 32'hFF);
    rchk(ADDR_GLOBAL_CTRL, 32'hC0);
  endtask : t_sw

  task t_irq;
    wr(ADDR_GLOBAL_CTRL, 32'h0);
    wr(ADDR_FLAG6, 32'h0);
    wr(ADDR_ENABLE6, 32'h01);
    outs(3'h0);
    i_src.pulse(14'h0008);
    outs(3'h4);
    wr(ADDR_GLOBAL_CTRL, 32'h80);
    outs(3'h4);
    wr(ADDR_GLOBAL_CTRL, 32'h40);
    outs(3'h4);
    wr(ADDR_GLOBAL_CTRL, 32'hC0);
    outs(3'h6);
    rchk(ADDR_EVT_STATUS, 32'h1);
    wr(ADDR_EVT_MASK, 32'h1);
    outs(3'h7);
    wr(ADDR_FLAG6, 32'h0);
    outs(3'h1);
    wr(ADDR_EVT_STATUS, 32'h1);
    outs(3'h0);
    wr(8'h3C, 32'h1, RESP_SLVERR);
    rchk(ADDR_EVT_STATUS, 32'h2);
    rchk(8'h3C, 32'h0, RESP_SLVERR);
    wr(ADDR_EVT_MASK, 32'h2);
    outs(3'h1);
  endtask : t_irq

  // Reset in mid-run with flags standing
  task t_rst2;
    wr(ADDR_FLAG7, 32'hFF);
    @(posedge i_ref_clk);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    outs(3'h0);
    rchk(ADDR_FLAG7, 32'h0);
  endtask : t_rst2

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    t_reset();
    t_events();
    t_sw();
    t_irq();
    t_rst2();
    results();
  end
endmodule : tb_peripheral_irq_flags_4_to_7
